/* ram_coef_decim_filter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "filt_defines.svh"

module ram_coef_decim_filter (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  filt_link_if.device       lnk,
  input  wire logic         sleepReq,
  input  wire logic         softSync,
  input  wire logic         altValid,
  input  wire logic [19:0]  altI,
  input  wire logic [19:0]  altQ,
  output logic              altReady,
  input  wire logic         regWr,
  input  wire logic         regRd,
  input  wire logic [7:0]   regAddr,
  input  wire logic [19:0]  regWrData,
  output logic [19:0]       regRdData,
  output logic              regRdValid,
  output logic              outValid,
  output logic [23:0]       outI,
  output logic [23:0]       outQ,
  output logic [3:0]        outExpI,
  output logic [3:0]        outExpQ,
  output logic [1:0]        outFormat
);

  filt_pkg::dev_regs_t r;
  filt_pkg::dev_regs_t n;

  logic [19:0]        coefMem [0:`COEFFICIENT_MEMORY_DEPTH-1];
  logic [19:0]        memI    [0:`SMEM_DEPTH-1];
  logic [19:0]        memQ    [0:`SMEM_DEPTH-1];
  logic               cWe;
  logic [7:0]         cWa;
  logic [19:0]        cWd;
  logic               dWe;
  logic [7:0]         dWa;
  logic [19:0]        dWI;
  logic [19:0]        dWQ;
  logic               altSel;
  logic               push;
  logic [19:0]        pushI;
  logic [19:0]        pushQ;

  // Redundant sign bits of a 24-bit word, capped at 15
  function automatic logic [3:0] headroom(input logic [23:0] v);
    logic [3:0] cnt;
    logic       stop;
    cnt  = 4'h0;
    stop = 1'b0;
    for (int i = 22; i >= 0; i--) begin
      if (!stop && v[i] == v[23] && cnt != 4'hF) begin
        cnt = cnt + 4'h1;
      end else begin
        stop = 1'b1;
      end
    end
    return cnt;
  endfunction

  // Negative full-scale sine, eight points per period
  function automatic logic [19:0] negSine(input logic [2:0] ph);
    unique case (ph)
      3'h0, 3'h4: negSine = 20'h00000;
      3'h1, 3'h3: negSine = 20'hA57D9;
      3'h2:       negSine = 20'h80000;
      3'h5, 3'h7: negSine = 20'h5A827;
      default:    negSine = 20'h7FFFF;
    endcase
  endfunction

  // Alternate comb source shares the two-entry buffer with the link
  assign altSel         = r.ctrl[`CTL_ALT_SRC];
  assign lnk.inputReady = r.awake && !altSel && r.bufCnt != 2'h2;
  assign altReady       = r.awake && altSel && r.bufCnt != 2'h2;
  assign lnk.chanAwake  = r.awake;
  assign push           = altSel ? (altValid && altReady) : (lnk.inputEnable && lnk.inputReady);
  assign pushI          = altSel ? altI : lnk.sampleI;
  assign pushQ          = altSel ? altQ : lnk.sampleQ;

  assign regRdData  = r.rdData;
  assign regRdValid = r.rdValid;
  assign outValid   = r.outValid;
  assign outI       = r.outI;
  assign outQ       = r.outQ;
  assign outExpI    = r.expI;
  assign outExpQ    = r.expQ;
  assign outFormat  = r.ctrl[`CTL_FMT_LSB+1:`CTL_FMT_LSB];

  // Next-state logic for the whole channel
  always_comb begin
    logic               stActive;
    logic               genMode;
    logic               take;
    logic               pop;
    logic [19:0]        smpI;
    logic [19:0]        smpQ;
    logic [19:0]        pat;
    logic [7:0]         nT1;
    logic [8:0]         oldest;
    logic [7:0]         wrNext;
    logic signed [39:0] prodI;
    logic signed [39:0] prodQ;
    logic [47:0]        shI;
    logic [47:0]        shQ;
    logic [3:0]         eI;
    logic [3:0]         eQ;
    logic [23:0]        mI;
    logic [23:0]        mQ;
    logic [1:0]         cntA;
    n        = r;
    stActive = 1'b0;
    genMode  = 1'b0;
    take     = 1'b0;
    pop      = 1'b0;
    smpI     = r.bufI[0];
    smpQ     = r.bufQ[0];
    pat      = {r.mtAddr[7:0] ^ 8'hA5, r.mtAddr[7:0], ~r.mtAddr[3:0]};
    nT1      = (r.ntaps > 8'h9F) ? 8'h9F : r.ntaps;
    wrNext   = (r.wrPtr == 8'(`SMEM_DEPTH - 1)) ? 8'h00 : r.wrPtr + 8'h01;
    oldest   = {1'b0, wrNext} + 9'(`SMEM_DEPTH) - {1'b0, nT1} - 9'h001;
    prodI    = $signed(memI[r.rdPtr]) * $signed(coefMem[8'(r.coefOff + r.tapIdx)]);
    prodQ    = $signed(memQ[r.rdPtr]) * $signed(coefMem[8'(r.coefOff + r.tapIdx)]);
    shI      = r.accI << r.ctrl[3:0];
    shQ      = r.accQ << r.ctrl[3:0];
    eI       = headroom(r.accI[42:19]);
    eQ       = headroom(r.accQ[42:19]);
    mI       = 24'h000000;
    mQ       = 24'h000000;
    cntA     = r.bufCnt;
    cWe      = 1'b0;
    cWa      = 8'h00;
    cWd      = 20'h00000;
    dWe      = 1'b0;
    dWa      = r.wrPtr;
    dWI      = 20'h00000;
    dWQ      = 20'h00000;
    n.outValid = 1'b0;
    n.rdValid  = 1'b0;
    if (oldest >= 9'(`SMEM_DEPTH)) begin
      oldest = oldest - 9'(`SMEM_DEPTH);
    end

    // Stimulus choice while a channel self-test runs
    stActive = r.stCount != 20'h00000;
    genMode  = stActive && r.stim != 2'h0;
    if (genMode) begin
      smpI = r.stim[1] ? r.lfsr : negSine(r.sinePh);
      smpQ = r.stim[1] ? ~r.lfsr : negSine(r.sinePh + 3'h2);
    end

    // Soft sync wakes the channel and re-arms the phase
    if (softSync) begin
      n.awake  = 1'b1;
      n.decCnt = r.phase;
    end else if (sleepReq) begin
      n.awake = 1'b0;
    end

    unique case (r.state)
      filt_pkg::ST_IDLE: begin
        if (r.awake && (genMode || r.bufCnt != 2'h0)) begin
          take = 1'b1;
          pop  = !genMode;
          if (r.ctrl[`CTL_BYPASS]) begin
            // Bypass path replaces the filter
            n.accI  = {{9{smpI[19]}}, smpI, 19'h00000};
            n.accQ  = {{9{smpQ[19]}}, smpQ, 19'h00000};
            n.state = filt_pkg::ST_OUT;
          end else begin
            // Circular store, newest at the write pointer
            dWe     = 1'b1;
            dWI     = smpI;
            dWQ     = smpQ;
            n.wrPtr = wrNext;
            if (r.decCnt == r.decim) begin
              // Wrap after decim plus one inputs triggers one output
              n.decCnt = 8'h00;
              n.state  = filt_pkg::ST_CALC;
              n.tapIdx = 8'h00;
              n.rdPtr  = oldest[7:0];
              n.accI   = 48'h000000000000;
              n.accQ   = 48'h000000000000;
            end else begin
              n.decCnt = r.decCnt + 8'h01;
            end
          end
        end
      end
      filt_pkg::ST_CALC: begin
        // One tap per cycle, older data with lower coefficient address
        n.accI   = r.accI + {{8{prodI[39]}}, prodI};
        n.accQ   = r.accQ + {{8{prodQ[39]}}, prodQ};
        n.rdPtr  = (r.rdPtr == 8'(`SMEM_DEPTH - 1)) ? 8'h00 : r.rdPtr + 8'h01;
        n.tapIdx = r.tapIdx + 8'h01;
        if (r.tapIdx == nT1) begin
          n.state = filt_pkg::ST_OUT;
        end
      end
      filt_pkg::ST_OUT: begin
        n.state    = filt_pkg::ST_IDLE;
        n.outValid = 1'b1;
        if (r.ctrl[`CTL_FORCE_EXP]) begin
          eI = r.ctrl[3:0];
          eQ = r.ctrl[3:0];
        end else if (r.ctrl[`CTL_COMMON_EXP]) begin
          // Smaller shift of the two keeps both in range
          eI = (eI < eQ) ? eI : eQ;
          eQ = eI;
        end
        mI = r.accI[42:19] << eI;
        mQ = r.accQ[42:19] << eQ;
        if (r.ctrl[5]) begin
          n.outI = {{12{mI[23]}}, mI[23:12]};
          n.outQ = {{12{mQ[23]}}, mQ[23:12]};
          n.expI = eI;
          n.expQ = eQ;
        end else if (r.ctrl[4]) begin
          n.outI = {{16{mI[23]}}, mI[23:16]};
          n.outQ = {{16{mQ[23]}}, mQ[23:16]};
          n.expI = eI;
          n.expQ = eQ;
        end else begin
          n.outI = shI[42:19];
          n.outQ = shQ[42:19];
          n.expI = r.ctrl[3:0];
          n.expQ = r.ctrl[3:0];
        end
        // Independent I and Q signature compaction
        if (stActive) begin
          n.sigI    = {r.sigI[18:0], r.sigI[19] ^ r.sigI[16]} ^ n.outI[19:0];
          n.sigQ    = {r.sigQ[18:0], r.sigQ[19] ^ r.sigQ[16]} ^ n.outQ[19:0];
          n.stCount = r.stCount - 20'h00001;
        end
      end
      filt_pkg::ST_MT_WR: begin
        // Pattern fill of both memories
        cWe      = 1'b1;
        cWa      = r.mtAddr[7:0];
        cWd      = pat;
        dWe      = r.mtAddr < 9'(`SMEM_DEPTH);
        dWa      = r.mtAddr[7:0];
        dWI      = pat;
        dWQ      = ~pat;
        n.mtAddr = r.mtAddr + 9'h001;
        if (r.mtAddr == 9'(`COEFFICIENT_MEMORY_DEPTH - 1)) begin
          n.state  = filt_pkg::ST_MT_RD;
          n.mtAddr = 9'h000;
        end
      end
      filt_pkg::ST_MT_RD: begin
        if (coefMem[r.mtAddr[7:0]] != pat) begin
          n.memStat[`MT_COEFFICIENT_MEMORY_BAD] = 1'b1;
        end
        if (r.mtAddr < 9'(`SMEM_DEPTH) && (memI[r.mtAddr[7:0]] != pat || memQ[r.mtAddr[7:0]] != ~pat)) begin
          n.memStat[`MT_SAMPLE_MEMORY_BAD] = 1'b1;
        end
        n.mtAddr = r.mtAddr + 9'h001;
        if (r.mtAddr == 9'(`COEFFICIENT_MEMORY_DEPTH - 1)) begin
          n.state  = filt_pkg::ST_CLEAR;
          n.mtAddr = 9'h000;
        end
      end
      filt_pkg::ST_CLEAR: begin
        // Zero the sample memory so no stale taps leak out
        dWe      = 1'b1;
        dWa      = r.mtAddr[7:0];
        n.mtAddr = r.mtAddr + 9'h001;
        if (r.mtAddr == 9'(`SMEM_DEPTH - 1)) begin
          n.state              = filt_pkg::ST_IDLE;
          n.memStat[`MT_BUSY]  = 1'b0;
          n.wrPtr              = 8'h00;
        end
      end
    endcase

    if (take && genMode) begin
      n.lfsr   = {r.lfsr[18:0], r.lfsr[19] ^ r.lfsr[16]};
      n.sinePh = r.sinePh + 3'h1;
    end

    // Two-entry input buffer; a full buffer stalls the sender
    if (pop) begin
      cntA      = r.bufCnt - 2'h1;
      n.bufI[0] = r.bufI[1];
      n.bufQ[0] = r.bufQ[1];
    end
    if (push) begin
      n.bufI[cntA[0]] = pushI;
      n.bufQ[cntA[0]] = pushQ;
    end
    n.bufCnt = cntA + {1'b0, push};

    // Register writes; hardware events above are overridden by the addressed field, and decimation or phase writes also reload decCnt
    if (regWr) begin
      if (regAddr <= `OFS_COEF_LAST) begin
        if (r.state != filt_pkg::ST_MT_WR) begin
          cWe = 1'b1;
          cWa = {r.ctrl[`CTL_PAGE], regAddr[6:0]};
          cWd = regWrData;
        end
      end else begin
        unique case (regAddr)
          `OFS_DECIM: begin
            n.decim  = regWrData[7:0];
            n.decCnt = r.phase;
          end
          `OFS_PHASE: begin
            n.phase  = regWrData[7:0];
            n.decCnt = regWrData[7:0];
          end
          `OFS_NTAPS:    n.ntaps   = regWrData[7:0];
          `OFS_COEF_OFF: n.coefOff = regWrData[7:0];
          `OFS_CTRL:     n.ctrl    = regWrData[10:0];
          `OFS_SIG_I:    n.sigI    = regWrData;
          `OFS_SIG_Q:    n.sigQ    = regWrData;
          `OFS_ST_CTRL:  n.stCount = regWrData;
          `OFS_MEM_TEST: begin
            if (regWrData[0] && r.state == filt_pkg::ST_IDLE) begin
              n.state   = filt_pkg::ST_MT_WR;
              n.mtAddr  = 9'h000;
              n.memStat = 3'h1;
            end
          end
          `OFS_MEM_CLEAR: begin
            if (r.state == filt_pkg::ST_IDLE) begin
              n.state             = filt_pkg::ST_CLEAR;
              n.mtAddr            = 9'h000;
              n.memStat[`MT_BUSY] = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
    // Stimulus select sits apart, since the count fills the whole data word
    if (regWr && regAddr == `OFS_ST_STIM) begin
      n.stim = regWrData[`ST_STIM_LSB+1:`ST_STIM_LSB];
    end

    // Registered read answer, unmapped offsets read zero
    if (regRd) begin
      n.rdValid = 1'b1;
      unique case (regAddr)
        `OFS_DECIM:    n.rdData = {12'h000, r.decim};
        `OFS_PHASE:    n.rdData = {12'h000, r.phase};
        `OFS_NTAPS:    n.rdData = {12'h000, r.ntaps};
        `OFS_COEF_OFF: n.rdData = {12'h000, r.coefOff};
        `OFS_CTRL:     n.rdData = {9'h000, r.ctrl};
        `OFS_SIG_I:    n.rdData = r.sigI;
        `OFS_SIG_Q:    n.rdData = r.sigQ;
        `OFS_ST_CTRL:  n.rdData = r.stCount;
        `OFS_MEM_TEST: n.rdData = {17'h00000, r.memStat};
        default:       n.rdData = (regAddr <= `OFS_COEF_LAST) ? coefMem[{r.ctrl[`CTL_PAGE], regAddr[6:0]}] : 20'h00000;
      endcase
    end
  end

  // State register; clock enable freezes everything except the synchronous reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r       <= '0;
      r.state <= filt_pkg::ST_IDLE;
      r.lfsr  <= `RST_LFSR;
    end else if (ce) begin
      r <= n;
    end
  end

  // Memory write ports; contents survive reset, hence the clear sequence
  always_ff @(posedge core_clk) begin
    if (ce && cWe) begin
      coefMem[cWa] <= cWd;
    end
    if (ce && dWe) begin
      memI[dWa] <= dWI;
      memQ[dWa] <= dWQ;
    end
  end

endmodule // ram_coef_decim_filter

`default_nettype wire

/* filt_defines.svh */
`ifndef FILT_DEFINES_SVH
`define FILT_DEFINES_SVH

// Register offsets
`define OFS_COEF_LAST   8'h7F
`define OFS_DECIM       8'hA0
`define OFS_PHASE       8'hA1
`define OFS_NTAPS       8'hA2
`define OFS_COEF_OFF    8'hA3
`define OFS_CTRL        8'hA4
`define OFS_SIG_I       8'hA5
`define OFS_SIG_Q       8'hA6
`define OFS_ST_CTRL     8'hA7
`define OFS_MEM_TEST    8'hA8
`define OFS_MEM_CLEAR   8'hA9
`define OFS_ST_STIM     8'hAA

// Output scale and control fields
`define CTL_SCALE_LSB   0
`define CTL_FMT_LSB     4
`define CTL_FORCE_EXP   6
`define CTL_COMMON_EXP  7
`define CTL_PAGE        8
`define CTL_ALT_SRC     9
`define CTL_BYPASS      10

// Self-test stimulus select: zero off, 1 sine, bit 1 set pseudo-random whatever bit 0 holds
`define ST_STIM_LSB     0

// Memory self-test status fields
`define MT_BUSY         0
`define MT_COEFFICIENT_MEMORY_BAD     1
`define MT_SAMPLE_MEMORY_BAD     2

// Memory sizes and counts
`define SMEM_DEPTH      160
`define COEFFICIENT_MEMORY_DEPTH      256
`define MEMTEST_WAIT    1600

// Reset values
`define RST_LFSR        20'h00001

`endif

/* filt_pkg.sv */
`default_nettype none

package filt_pkg;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_CALC  = 6'h02,
    ST_OUT   = 6'h04,
    ST_MT_WR = 6'h08,
    ST_MT_RD = 6'h10,
    ST_CLEAR = 6'h20
  } filt_state_t;

  typedef struct packed {
    filt_state_t      state;
    logic [7:0]       decim;
    logic [7:0]       phase;
    logic [7:0]       ntaps;
    logic [7:0]       coefOff;
    logic [10:0]      ctrl;
    logic [19:0]      sigI;
    logic [19:0]      sigQ;
    logic [19:0]      stCount;
    logic [1:0]       stim;
    logic [2:0]       memStat;
    logic             awake;
    logic [7:0]       decCnt;
    logic [7:0]       tapIdx;
    logic [7:0]       rdPtr;
    logic [7:0]       wrPtr;
    logic [47:0]      accI;
    logic [47:0]      accQ;
    logic [1:0][19:0] bufI;
    logic [1:0][19:0] bufQ;
    logic [1:0]       bufCnt;
    logic [19:0]      lfsr;
    logic [2:0]       sinePh;
    logic [8:0]       mtAddr;
    logic [23:0]      outI;
    logic [23:0]      outQ;
    logic [3:0]       expI;
    logic [3:0]       expQ;
    logic             outValid;
    logic [19:0]      rdData;
    logic             rdValid;
  } dev_regs_t;

  typedef struct packed {
    logic        holdValid;
    logic [19:0] holdI;
    logic [19:0] holdQ;
  } comb_regs_t;

endpackage

`default_nettype wire

/* filt_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

// Sample link from the comb stage to the coefficient filter
interface filt_link_if;
  logic        inputEnable;
  logic        inputReady;
  logic [19:0] sampleI;
  logic [19:0] sampleQ;
  logic        chanAwake;

  modport device (input inputEnable, input sampleI, input sampleQ, output inputReady, output chanAwake);
  modport comb   (output inputEnable, output sampleI, output sampleQ, input inputReady, input chanAwake);
endinterface

`default_nettype wire

/* comb_stage_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "filt_defines.svh"

module comb_stage_end (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic         combValid,
  input  wire logic [19:0]  combI,
  input  wire logic [19:0]  combQ,
  output logic              combReady,
  filt_link_if.comb         lnk
);

  filt_pkg::comb_regs_t r;
  filt_pkg::comb_regs_t n;
  logic                 sent;

  // Offer a word only while the channel is awake, never during sleep
  assign lnk.inputEnable = r.holdValid && lnk.chanAwake;
  assign lnk.sampleI     = r.holdI;
  assign lnk.sampleQ     = r.holdQ;
  assign sent            = lnk.inputEnable && lnk.inputReady;
  assign combReady       = !r.holdValid || sent;

  // One holding stage; refills in the cycle it empties
  always_comb begin
    n = r;
    if (sent) begin
      n.holdValid = 1'b0;
    end
    if (combValid && combReady) begin
      n.holdValid = 1'b1;
      n.holdI     = combI;
      n.holdQ     = combQ;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

endmodule // comb_stage_end

`default_nettype wire

/* filt_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

// Watches the sample link between the comb end and the filter end
module filt_link_monitor (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        inputEnable,
  input  wire logic        inputReady,
  input  wire logic [19:0] sampleI,
  input  wire logic [19:0] sampleQ,
  input  wire logic        chanAwake
);
  default clocking cb @(posedge core_clk); endclocking

  // Offers only while awake, and held whole until taken
  property p_enable_awake;
    disable iff (sys_rst) inputEnable |-> chanAwake;
  endproperty
  property p_hold_offer;
    disable iff (sys_rst) inputEnable && !inputReady |=> !chanAwake || (inputEnable && $stable(sampleI) && $stable(sampleQ));
  endproperty
  property p_drop_after_take;
    disable iff (sys_rst) $fell(inputEnable) |-> $past(inputReady) || !chanAwake;
  endproperty
  property p_sleep_refuses;
    disable iff (sys_rst) !chanAwake |-> !inputReady;
  endproperty
  // Reset leaves the channel asleep and the link quiet
  property p_reset_sleep;
    sys_rst |=> !chanAwake;
  endproperty
  property p_reset_quiet;
    sys_rst |=> !inputEnable && !inputReady;
  endproperty
  // A stall must end; worst case is a full tap run per buffered word
  property p_ready_bounded;
    disable iff (sys_rst) inputEnable |-> ##[0:400] inputReady;
  endproperty
  property p_wake_clean;
    disable iff (sys_rst) $rose(chanAwake) |-> !$past(inputEnable);
  endproperty

  a_enable_awake: assert property (p_enable_awake)
    else $error("link offer while channel asleep");
  a_hold_offer: assert property (p_hold_offer)
    else $error("link word changed before it was taken");
  a_drop_after_take: assert property (p_drop_after_take)
    else $error("link offer withdrawn without a take");
  a_sleep_refuses: assert property (p_sleep_refuses)
    else $error("sleeping channel signals ready");
  a_reset_sleep: assert property (p_reset_sleep)
    else $error("channel awake after reset");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("link active after reset");
  a_ready_bounded: assert property (p_ready_bounded)
    else $error("link stall did not end");
  a_wake_clean: assert property (p_wake_clean)
    else $error("link offered before wake");

  c_take: cover property (disable iff (sys_rst) inputEnable && inputReady);
  c_stall: cover property (disable iff (sys_rst) inputEnable && !inputReady);
  c_wake: cover property (disable iff (sys_rst) $rose(chanAwake));
endmodule // filt_link_monitor

`default_nettype wire

/* ram_coef_decim_filter_built_in_self_test_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "filt_defines.svh"

`define CHK(nm, ex, gt) begin comparisons++; if ((ex) !== (gt)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end

module ram_coef_decim_filter_built_in_self_test_test;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        ce = 1'b1;
  logic        combValid = 1'b0, combReady, sleepReq = 1'b0, softSync = 1'b0;
  logic [19:0] combI = 20'h00000, combQ = 20'h00000, altI = 20'h00000, altQ = 20'h00000;
  logic        altValid = 1'b0, altReady, regWr = 1'b0, regRd = 1'b0, regRdValid, outValid;
  logic [7:0]  regAddr = 8'h00;
  logic [19:0] regWrData = 20'h00000, regRdData, rdVal, v, q, sigI, sigQ;
  logic [23:0] outI, outQ, expI[$], expQ[$], gotI[$], gotQ[$];
  logic [3:0]  outExpI, outExpQ;
  logic [1:0]  outFormat;
  logic [7:0]  expE[$], gotE[$];
  int          miscompares = 0, comparisons = 0, seed = 88, n;

  filt_link_if filt_link_if_inst ();
  comb_stage_end comb_stage_end_inst (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .combValid(combValid),
    .combI(combI), .combQ(combQ), .combReady(combReady), .lnk(filt_link_if_inst));
  ram_coef_decim_filter ram_coef_decim_filter_inst (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce),
    .lnk(filt_link_if_inst), .sleepReq(sleepReq), .softSync(softSync), .altValid(altValid), .altI(altI),
    .altQ(altQ), .altReady(altReady), .regWr(regWr), .regRd(regRd), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .outValid(outValid), .outI(outI), .outQ(outQ),
    .outExpI(outExpI), .outExpQ(outExpQ), .outFormat(outFormat));
  filt_link_monitor filt_link_monitor_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .inputEnable(filt_link_if_inst.inputEnable), .inputReady(filt_link_if_inst.inputReady),
    .sampleI(filt_link_if_inst.sampleI), .sampleQ(filt_link_if_inst.sampleQ),
    .chanAwake(filt_link_if_inst.chanAwake));

  // 200 MHz master clock
  always #2.5 core_clk = ~core_clk;

  // Registered outputs are read before this edge updates them
  always @(posedge core_clk) begin
    if (outValid === 1'b1) begin
      gotI.push_back(outI);
      gotQ.push_back(outQ);
      gotE.push_back({outExpI, outExpQ});
    end
  end

  // Signature model: shift with feedback, then fold in the output word
  function automatic logic [19:0] misr(input logic [19:0] s, input logic [19:0] d);
    return {s[18:0], s[19] ^ s[16]} ^ d;
  endfunction

  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic timeout;
    miscompares++;
    $display("MISMATCH wait expected done seen timeout");
    give_verdict();
  endtask

  task automatic wr(input logic [7:0] a, input logic [19:0] d);
    @(posedge core_clk);
    #1 regWr = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge core_clk);
    #1 regWr = 1'b0;
  endtask

  // Read data is valid exactly one cycle after the read edge
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    #1 regRd = 1'b1;
    regAddr = a;
    @(posedge core_clk);
    #1 regRd = 1'b0;
    rdVal = (regRdValid === 1'b1) ? regRdData : 20'hFFFFF;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [19:0] e);
    rd(a);
    `CHK("register read", e, rdVal)
  endtask

  // One cycle of wake or sleep request
  task automatic ctl(input logic wake);
    @(posedge core_clk);
    #1 softSync = wake;
    sleepReq = !wake;
    @(posedge core_clk);
    #1 softSync = 1'b0;
    sleepReq = 1'b0;
  endtask

  // Word held until the chosen source takes it; returns on the taking edge
  task automatic send(input logic alt, input logic [19:0] i, input logic [19:0] qv);
    logic ok;
    ok = 1'b0;
    #1 combI = i;
    combQ = qv;
    altI = i;
    altQ = qv;
    altValid = alt;
    combValid = !alt;
    for (int k = 0; k < 500 && !ok; k++) begin
      ok = ((alt ? altReady : combReady) === 1'b1);
      @(posedge core_clk);
    end
    if (!ok) timeout();
  endtask

  task automatic drain(input int cnt);
    #1 combValid = 1'b0;
    altValid = 1'b0;
    for (n = 0; n < 4000 && gotI.size() < cnt; n++) @(posedge core_clk);
    if (gotI.size() < cnt) timeout();
    repeat (8) @(posedge core_clk);
    `CHK("output count", cnt, gotI.size())
    for (n = 0; n < expI.size() && n < cnt; n++) begin
      `CHK("outI", expI[n], gotI[n])
      `CHK("outQ", expQ[n], gotQ[n])
    end
    for (n = 0; n < expE.size() && n < cnt; n++) `CHK("exponents", expE[n], gotE[n])
    expI.delete();
    expQ.delete();
    expE.delete();
    gotI.delete();
    gotQ.delete();
    gotE.delete();
  endtask

  // Main sequence: registers, memory test, filter, float, bypass
  initial begin
    repeat (10) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    for (int a = 0; a < 4; a++) begin
      v = 20'($random(seed));
      wr(8'hA0 + 8'(a), {12'h000, v[7:0]});
      chk_rd(8'hA0 + 8'(a), {12'h000, v[7:0]});
    end
    wr(8'hB3, 20'hFFFFF);
    chk_rd(8'hB3, 20'h00000);
    for (int f = 0; f < 4; f++) begin
      wr(`OFS_CTRL, {14'h0000, 2'(f), 4'h9});
      `CHK("outFormat", 2'(f), outFormat)
      chk_rd(`OFS_CTRL, {14'h0000, 2'(f), 4'h9});
    end
    wr(`OFS_MEM_TEST, 20'h00001);
    chk_rd(`OFS_MEM_TEST, 20'h00001);
    // Software waits the full test time before looking at the result
    repeat (1600) @(posedge core_clk);
    rd(`OFS_MEM_TEST);
    `CHK("memory test status", 20'h00000, rdVal)
    // Taps straddle the page boundary; only the newest carries weight
    wr(`OFS_CTRL, 20'h00100);
    wr(8'h00, 20'h40000);
    chk_rd(8'h00, 20'h40000);
    wr(`OFS_CTRL, 20'h00001);
    wr(8'h7E, 20'h00000);
    wr(8'h7F, 20'h00000);
    wr(`OFS_MEM_CLEAR, 20'h00000);
    repeat (170) @(posedge core_clk);
    wr(`OFS_DECIM, 20'h00003);
    wr(`OFS_PHASE, 20'h00000);
    wr(`OFS_NTAPS, 20'h00002);
    wr(`OFS_COEF_OFF, 20'h0007E);
    wr(`OFS_SIG_I, 20'h00000);
    wr(`OFS_SIG_Q, 20'h00000);
    wr(`OFS_ST_CTRL, 20'h00004);
    ctl(1'b1);
    `CHK("chanAwake", 1'b1, filt_link_if_inst.chanAwake)
    sigI = 20'h00000;
    sigQ = 20'h00000;
    for (int g = 0; g < 4; g++) begin
      v = 20'($random(seed));
      q = 20'($random(seed));
      expI.push_back({{4{v[19]}}, v});
      expQ.push_back({{4{q[19]}}, q});
      sigI = misr(sigI, v);
      sigQ = misr(sigQ, q);
      repeat (4) send(1'b0, v, q);
    end
    drain(4);
    chk_rd(`OFS_SIG_I, sigI);
    chk_rd(`OFS_SIG_Q, sigQ);
    chk_rd(`OFS_ST_CTRL, 20'h00000);
    // Phase 2 makes the first output come after two samples
    wr(`OFS_CTRL, 20'h00065);
    wr(`OFS_PHASE, 20'h00002);
    for (int k = 0; k < 6; k++) send(1'b0, 20'($random(seed)), 20'($random(seed)));
    expE = {8'h55, 8'h55};
    drain(2);
    wr(`OFS_CTRL, 20'h00600);
    `CHK("inputReady", 1'b0, filt_link_if_inst.inputReady)
    for (int k = 0; k < 3; k++) begin
      v = 20'($random(seed));
      q = 20'($random(seed));
      expI.push_back({{4{v[19]}}, v});
      expQ.push_back({{4{q[19]}}, q});
      send(1'b1, v, q);
    end
    drain(3);
    // Shared auto exponent: the larger Q word sets the shift for both
    wr(`OFS_CTRL, 20'h006A0);
    expI.push_back(24'h000001);
    expQ.push_back(24'h000400);
    expE.push_back(8'h44);
    send(1'b1, 20'h00100, 20'h40000);
    drain(1);
    // Internal negative sine through the bypass, three outputs then stop
    wr(`OFS_CTRL, 20'h00600);
    wr(`OFS_ST_STIM, 20'h00001);
    expI = {24'h000000, 24'hFA57D9, 24'hF80000};
    expQ = {24'hF80000, 24'hFA57D9, 24'h000000};
    wr(`OFS_ST_CTRL, 20'h00003);
    drain(3);
    chk_rd(`OFS_ST_CTRL, 20'h00000);
    ctl(1'b0);
    `CHK("chanAwake", 1'b0, filt_link_if_inst.chanAwake)
    give_verdict();
  end
endmodule // ram_coef_decim_filter_built_in_self_test_test

`default_nettype wire
